// >>> hdl/meoc_defines.vh
// Offsets, field positions, reset values and codes of the option block.
// Assumes inclusion by bare name from the design file.
`ifndef MEOC_DEFINES_VH
`define MEOC_DEFINES_VH

// ****************************************
// Register word offsets (byte addresses)
// ****************************************
`define MEOC_ADDR_CMD 6'h00
`define MEOC_ADDR_OPT 6'h04
`define MEOC_ADDR_CTL 6'h08
`define MEOC_ADDR_STS 6'h0c
`define MEOC_ADDR_VIEW 6'h10

// ****************************************
// Command word fields
// ****************************************
`define MEOC_CMD_VAL_LSB 0
`define MEOC_CMD_OP_LSB 8

// Command opcodes
`define MEOC_OP_DEFAULTS 4'h0
`define MEOC_OP_GUARD 4'h1
`define MEOC_OP_RELAY 4'h2
`define MEOC_OP_FLOW 4'h3
`define MEOC_OP_LINE 4'h4
`define MEOC_OP_MODE 4'h5
`define MEOC_OP_PULSE 4'h6
`define MEOC_OP_CTS 4'h7
`define MEOC_OP_DSR 4'h8
`define MEOC_OP_TEST 4'h9
`define MEOC_OP_TRELLIS 4'ha
`define MEOC_OP_VIEW 4'hb

// ****************************************
// Reset / factory values
// ****************************************
`define MEOC_GUARD_RST 2'h0
`define MEOC_RELAY_RST 1'b0
`define MEOC_FLOW_RST 3'h3
`define MEOC_LINE_RST 1'b0
`define MEOC_MODE_RST 3'h0
`define MEOC_PULSE_RST 1'b0
`define MEOC_CTS_RST 1'b1
`define MEOC_DSR_RST 1'b0
`define MEOC_TRELLIS_RST 1'b0

// Flow codes
`define MEOC_FLOW_OFF 3'h0
`define MEOC_FLOW_HW 3'h3
`define MEOC_FLOW_SW 3'h4

// Test codes
`define MEOC_TEST_END 4'h0
`define MEOC_TEST_LAL 4'h1
`define MEOC_TEST_LDL 4'h3
`define MEOC_TEST_GRANT 4'h4
`define MEOC_TEST_DENY 4'h5
`define MEOC_TEST_RDL 4'h6
`define MEOC_TEST_RDLST 4'h7
`define MEOC_TEST_LALST 4'h8

// Test states
`define MEOC_TS_NONE 3'h0
`define MEOC_TS_LAL 3'h1
`define MEOC_TS_LDL 3'h2
`define MEOC_TS_RDL 3'h3
`define MEOC_TS_RDLST 3'h4
`define MEOC_TS_LALST 3'h5

`endif

// >>> hdl/meoc_option_ctrl.v
// Modem extended option decoder with a classic Wishbone register slave.
// Assumes line-side status pins arrive asynchronously; bus is on clk.
// Assumes the bus master holds each request until it sees ack.
// What this block does
// - Guard tone option: 0 none, 1 gives 550Hz, 2 gives 1800Hz.
// - Relay option 1 closes relay only while off hook; 0 never.
// - Flow select: 0 off, 3 RTS/CTS default, 4 XON/XOFF; 1,2,5 reserved.
// - Line option: 0 dial-up default, 1 leased line.
// - Mode 0 async; 1-3 sync; mode 2 DTR dials/hangs; mode 3 talk/data.
// - Pulse ratio 0 is 39/61 make/break; 1 is 33/67.
// - CTS option, while off hook: 0 in sync mode CTS follows RTS; 1 holds CTS on.
// - DSR: mode 0 option 0 always on; else on during handshake rules.
// - Test value 0 ends a test or loopback from 1, 3, 6, 7 or 8, back to normal; a grant by 4 stays.
// - Test 1 analog loop, 3 digital loop, 8 analog loop with test.
// - Test 4 grants far loopback requests, 5 refuses them.
// - Test 6 starts remote loopback, 7 remote loopback with test.
// - View 0 or 1 reports active setup with stored profile 0 or 1.
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "meoc_defines.vh"

module meoc_option_ctrl #(
   parameter AW = 6
) (
   input wire clk,
   input wire reset,
   input wire ce,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [AW-1:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire dtr_pin,
   input wire rts_pin,
   input wire off_hook_pin,
   input wire carrier_pin,
   input wire handshake_pin,
   input wire band_high_pin,
   input wire rdl_request_pin,
   output reg cts_out,
   output reg dsr_out,
   output reg relay_close,
   output reg guard_550,
   output reg guard_1800,
   output reg hw_flow_en,
   output reg sw_flow_en,
   output reg leased_line,
   output reg sync_mode,
   output reg dial_request,
   output reg hangup_request,
   output reg data_mode,
   output reg pulse_ratio_uk,
   output reg trellis_coding_disable,
   output reg [2:0] test_state,
   output reg test_band_high,
   output reg rdl_grant,
   output reg rdl_accept,
   output reg [1:0] view_profile,
   output reg view_pulse
);

   // ****************************************
   // Option state
   // ****************************************
   reg [1:0] guard_tone_select;
   reg aux_relay_control;
   reg [2:0] flow_control_select;
   reg line_type_select;
   reg [2:0] communication_mode_select;
   reg pulse_sel;
   reg cts_policy_select;
   reg dsr_policy_select;
   reg trellis_sel;
   reg rdl_allow;
   reg [2:0] tstate;
   reg [3:0] last_test;
   reg [1:0] view_sel;
   reg view_go;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Only the second flop is read; the first may go metastable
   localparam NP = 7;
   wire [NP-1:0] pin_raw;
   reg [NP-1:0] pin_s1;
   reg [NP-1:0] pin_s2;
   assign pin_raw = {rdl_request_pin, band_high_pin, handshake_pin,
      carrier_pin, off_hook_pin, rts_pin, dtr_pin};
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi = gi + 1) begin : g_sync
         always @(posedge clk) begin
            if (reset) begin
               pin_s1[gi] <= 1'b0;
               pin_s2[gi] <= 1'b0;
            end else if (ce) begin
               pin_s1[gi] <= pin_raw[gi];
               pin_s2[gi] <= pin_s1[gi];
            end
         end
      end
   endgenerate
   wire dtr_s = pin_s2[0];
   wire rts_s = pin_s2[1];
   wire hook_s = pin_s2[2];
   wire carr_s = pin_s2[3];
   wire hand_s = pin_s2[4];
   wire band_s = pin_s2[5];
   wire rdlq_s = pin_s2[6];
   reg dtr_d;

   // ****************************************
   // Bus decode
   // ****************************************
   // The ~ack term stops a held request from being taken twice
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr_cmd = req & wb_we_i & wb_sel_i[1] & wb_sel_i[0] &
      (wb_adr_i == `MEOC_ADDR_CMD);
   wire [3:0] op = wb_dat_i[`MEOC_CMD_OP_LSB +: 4];
   wire [3:0] val = wb_dat_i[`MEOC_CMD_VAL_LSB +: 4];

   // Commands arrive only through the command word
   always @(posedge clk) begin
      if (reset) begin
         guard_tone_select <= `MEOC_GUARD_RST;
         aux_relay_control <= `MEOC_RELAY_RST;
         flow_control_select <= `MEOC_FLOW_RST;
         line_type_select <= `MEOC_LINE_RST;
         communication_mode_select <= `MEOC_MODE_RST;
         pulse_sel <= `MEOC_PULSE_RST;
         cts_policy_select <= `MEOC_CTS_RST;
         dsr_policy_select <= `MEOC_DSR_RST;
         trellis_sel <= `MEOC_TRELLIS_RST;
         rdl_allow <= 1'b0;
         tstate <= `MEOC_TS_NONE;
         last_test <= 4'h0;
         view_sel <= 2'h0;
         view_go <= 1'b0;
      end else if (ce) begin
         view_go <= 1'b0;
         if (wr_cmd) begin
            case (op)
               `MEOC_OP_DEFAULTS: begin
                  guard_tone_select <= `MEOC_GUARD_RST;
                  aux_relay_control <= `MEOC_RELAY_RST;
                  flow_control_select <= `MEOC_FLOW_RST;
                  line_type_select <= `MEOC_LINE_RST;
                  communication_mode_select <= `MEOC_MODE_RST;
                  pulse_sel <= `MEOC_PULSE_RST;
                  cts_policy_select <= `MEOC_CTS_RST;
                  dsr_policy_select <= `MEOC_DSR_RST;
                  trellis_sel <= `MEOC_TRELLIS_RST;
               end
               `MEOC_OP_GUARD: begin
                  // Values above 2 are ignored
                  if (val <= 4'h2)
                     guard_tone_select <= val[1:0];
               end
               `MEOC_OP_RELAY: begin
                  if (val <= 4'h1)
                     aux_relay_control <= val[0];
               end
               `MEOC_OP_FLOW: begin
                  // Reserved codes leave the selection as it was
                  if (val == 4'h0 || val == 4'h3 || val == 4'h4)
                     flow_control_select <= val[2:0];
               end
               `MEOC_OP_LINE: begin
                  if (val <= 4'h1)
                     line_type_select <= val[0];
               end
               `MEOC_OP_MODE: begin
                  if (val <= 4'h4)
                     communication_mode_select <= val[2:0];
               end
               `MEOC_OP_PULSE: begin
                  if (val <= 4'h1)
                     pulse_sel <= val[0];
               end
               `MEOC_OP_CTS: begin
                  if (val <= 4'h1)
                     cts_policy_select <= val[0];
               end
               `MEOC_OP_DSR: begin
                  if (val <= 4'h1)
                     dsr_policy_select <= val[0];
               end
               `MEOC_OP_TEST: begin
                  last_test <= val;
                  // Grant and deny leave a running test alone
                  case (val)
                     `MEOC_TEST_END: tstate <= `MEOC_TS_NONE;
                     `MEOC_TEST_LAL: tstate <= `MEOC_TS_LAL;
                     `MEOC_TEST_LDL: tstate <= `MEOC_TS_LDL;
                     `MEOC_TEST_LALST: tstate <= `MEOC_TS_LALST;
                     `MEOC_TEST_GRANT: rdl_allow <= 1'b1;
                     `MEOC_TEST_DENY: rdl_allow <= 1'b0;
                     `MEOC_TEST_RDL: tstate <= `MEOC_TS_RDL;
                     `MEOC_TEST_RDLST: tstate <= `MEOC_TS_RDLST;
                     default: tstate <= tstate;
                  endcase
               end
               `MEOC_OP_TRELLIS: begin
                  if (val <= 4'h1)
                     trellis_sel <= val[0];
               end
               `MEOC_OP_VIEW: begin
                  if (val <= 4'h1) begin
                     view_sel <= {1'b1, val[0]};
                     view_go <= 1'b1;
                  end
               end
               default: view_go <= 1'b0;
            endcase
         end
      end
   end

   // ****************************************
   // Line-side behaviour
   // ****************************************
   wire is_sync = (communication_mode_select >= 3'h1) &&
      (communication_mode_select <= 3'h3);
   wire on_line = hook_s;
   wire testing = (tstate != `MEOC_TS_NONE);
   // Any test state drops the handshake form of DSR
   wire hand_dsr = hand_s & ~testing & (on_line | carr_s);

   always @(posedge clk) begin
      if (reset) begin
         dtr_d <= 1'b0;
         cts_out <= 1'b0;
         dsr_out <= 1'b0;
         relay_close <= 1'b0;
         guard_550 <= 1'b0;
         guard_1800 <= 1'b0;
         hw_flow_en <= 1'b0;
         sw_flow_en <= 1'b0;
         leased_line <= 1'b0;
         sync_mode <= 1'b0;
         dial_request <= 1'b0;
         hangup_request <= 1'b0;
         data_mode <= 1'b0;
         pulse_ratio_uk <= 1'b0;
         trellis_coding_disable <= 1'b0;
         test_state <= `MEOC_TS_NONE;
         test_band_high <= 1'b0;
         rdl_grant <= 1'b0;
         rdl_accept <= 1'b0;
         view_profile <= 2'h0;
         view_pulse <= 1'b0;
      end else if (ce) begin
         // Pin-driven outputs lag their pins by three clocks
         dtr_d <= dtr_s;
         guard_550 <= (guard_tone_select == 2'h1);
         guard_1800 <= (guard_tone_select == 2'h2);
         relay_close <= aux_relay_control & hook_s;
         hw_flow_en <= (flow_control_select == `MEOC_FLOW_HW);
         sw_flow_en <= (flow_control_select == `MEOC_FLOW_SW);
         leased_line <= line_type_select;
         sync_mode <= is_sync;
         // Dial on DTR rising, only from idle
         dial_request <= (communication_mode_select == 3'h2) &
            dtr_s & ~dtr_d & ~on_line;
         hangup_request <= (communication_mode_select == 3'h2) &
            ~dtr_s & on_line;
         data_mode <= (communication_mode_select == 3'h3) & dtr_s;
         pulse_ratio_uk <= pulse_sel;
         // Off line CTS stays low under either policy
         if (!on_line)
            cts_out <= 1'b0;
         else if (!cts_policy_select && is_sync)
            cts_out <= rts_s;
         else
            cts_out <= 1'b1;
         if (communication_mode_select == 3'h0 && !dsr_policy_select)
            dsr_out <= 1'b1;
         else
            dsr_out <= hand_dsr;
         trellis_coding_disable <= trellis_sel;
         test_state <= tstate;
         test_band_high <= band_s & ((tstate == `MEOC_TS_LAL) |
            (tstate == `MEOC_TS_LALST));
         rdl_grant <= rdl_allow;
         rdl_accept <= rdl_allow & rdlq_s;
         view_profile <= view_sel;
         view_pulse <= view_go;
      end
   end

   // ****************************************
   // Wishbone answer, one wait state
   // ****************************************
   reg [31:0] next_rdata;
   always @* begin
      next_rdata = 32'h0000_0000;
      case (wb_adr_i)
         `MEOC_ADDR_OPT: next_rdata = {14'h0000,
            trellis_sel,
            dsr_policy_select,
            cts_policy_select,
            pulse_sel,
            communication_mode_select,
            line_type_select,
            flow_control_select,
            aux_relay_control,
            guard_tone_select,
            4'h0};
         `MEOC_ADDR_CTL: next_rdata = {28'h0000000, last_test};
         `MEOC_ADDR_STS: next_rdata = {22'h000000,
            rdl_allow,
            tstate,
            carr_s,
            hand_s,
            hook_s,
            dtr_s,
            rts_s,
            band_s};
         `MEOC_ADDR_VIEW: next_rdata = {30'h00000000, view_sel};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data is registered so wb_dat_o comes from a flop
   always @(posedge clk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce) begin
         wb_ack_o <= req;
         if (req && !wb_we_i)
            wb_dat_o <= next_rdata;
      end
   end

endmodule
`default_nettype wire

// >>> test/meoc_props.sv
// Checker of the option block's port behaviour.
// Assumes it is bound to meoc_option_ctrl: one clock, sync reset.
`timescale 1ns/10ps
`default_nettype none
module meoc_props (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic off_hook_pin,
   input wire logic relay_close,
   input wire logic cts_out,
   input wire logic guard_550,
   input wire logic guard_1800,
   input wire logic hw_flow_en,
   input wire logic sw_flow_en,
   input wire logic sync_mode,
   input wire logic dial_request,
   input wire logic view_pulse,
   input wire logic [2:0] test_state
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // ****************
   // Port relations
   // ****************
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
   endsequence
   // Four cycles covers the pin synchroniser and output register
   sequence offline_s;
      (!off_hook_pin && ce) [*4];
   endsequence
   ack_wait_a: assert property (req_s |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a pulse one cycle after request");
   guard_excl_a: assert property (!(guard_550 && guard_1800))
      else $error("both guard tones on");
   relay_hook_a: assert property (offline_s |-> !relay_close)
      else $error("relay closed while on hook");
   flow_excl_a: assert property (!(hw_flow_en && sw_flow_en))
      else $error("both flow controls on");
   dial_pulse_a: assert property (dial_request |->
      sync_mode ##1 !dial_request)
      else $error("dial request outside sync mode or too long");
   cts_offline_a: assert property (offline_s |-> !cts_out)
      else $error("cts on while off line");
   test_range_a: assert property (test_state <= 3'h5)
      else $error("test state out of range");
   view_pulse_a: assert property ($rose(view_pulse) |=> !view_pulse)
      else $error("view pulse longer than one cycle");
endmodule
bind meoc_option_ctrl meoc_props chk_u (.*);
`default_nettype wire

// >>> test/meoc_dte_model.sv
// Data terminal model: drives DTR and RTS, gates its sending on CTS.
// Assumes the bench asks for levels; pins move just after an edge.
`timescale 1ns/10ps
`default_nettype none
module meoc_dte_model (
   input wire logic clk,
   input wire logic want_dtr,
   input wire logic want_rts,
   input wire logic cts_out,
   input wire logic hw_flow_en,
   output logic dtr_pin,
   output logic rts_pin,
   output logic tx_ok
);
   initial begin
      dtr_pin = 1'b0;
      rts_pin = 1'b0;
   end
   always @(posedge clk) begin
      dtr_pin <= want_dtr;
      rts_pin <= want_rts;
   end
   // Sends only while CTS is up under hardware flow control
   assign tx_ok = !hw_flow_en || cts_out;
endmodule
`default_nettype wire

// >>> test/tb_meoc_option_ctrl.sv
// Self-checking bench of the option block over classic Wishbone.
// Assumes meoc_defines.vh on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "meoc_defines.vh"
module tb_meoc_option_ctrl;
   logic clk = 0, reset = 1, ce = 1, wb_cyc_i = 0, wb_stb_i = 0;
   logic wb_we_i = 0, off_hook_pin = 0, carrier_pin = 0;
   logic handshake_pin = 0, band_high_pin = 0, rdl_request_pin = 0;
   logic want_dtr = 0, want_rts = 0, dtr_pin, rts_pin, sy;
   logic [5:0] wb_adr_i = 0;
   logic [3:0] wb_sel_i = 0, op, v;
   logic [31:0] wb_dat_i = 0, wb_dat_o, opt;
   logic wb_ack_o, cts_out, dsr_out, relay_close, guard_550, guard_1800;
   logic hw_flow_en, sw_flow_en, leased_line, sync_mode, dial_request;
   logic hangup_request, data_mode, pulse_ratio_uk, trellis_coding_disable;
   logic test_band_high, rdl_grant, rdl_accept, view_pulse;
   logic [2:0] test_state, m;
   logic [1:0] view_profile;
   logic [31:0] rq[$];
   logic [1:0] vq[$];
   logic [3:0] tc[5] = '{4'h1, 4'h3, 4'h8, 4'h6, 4'h7};
   logic [2:0] ts[5] = '{3'h1, 3'h2, 3'h5, 3'h3, 3'h4};
   int n_mismatch = 0, check_count = 0, ncyc = 0, ndial = 0;
   localparam logic [31:0] OPT_RST = {14'h0, `MEOC_TRELLIS_RST,
      `MEOC_DSR_RST, `MEOC_CTS_RST, `MEOC_PULSE_RST, `MEOC_MODE_RST,
      `MEOC_LINE_RST, `MEOC_FLOW_RST, `MEOC_RELAY_RST, `MEOC_GUARD_RST, 4'h0};
   meoc_option_ctrl dut_u (.*);
   meoc_dte_model dte_u (.clk(clk), .want_dtr(want_dtr),
      .want_rts(want_rts), .cts_out(cts_out), .hw_flow_en(hw_flow_en),
      .dtr_pin(dtr_pin), .rts_pin(rts_pin), .tx_ok());
   always #2.5 clk = !clk;
   // ****************
   // Tasks
   // ****************
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, s);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wb(input logic w, input logic [5:0] a,
         input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do
         @(posedge clk);
      while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
   endtask
   function automatic logic [31:0] upd(input logic [31:0] o,
         input logic [3:0] op, v);
      upd = o;
      case (op)
         `MEOC_OP_DEFAULTS: upd = OPT_RST;
         `MEOC_OP_GUARD: if (v < 3) upd[5:4] = v[1:0];
         `MEOC_OP_RELAY: if (v < 2) upd[6] = v[0];
         `MEOC_OP_FLOW: if (v == 0 || v == 3 || v == 4) upd[9:7] = v[2:0];
         `MEOC_OP_LINE: if (v < 2) upd[10] = v[0];
         `MEOC_OP_MODE: if (v < 5) upd[13:11] = v[2:0];
         `MEOC_OP_PULSE: if (v < 2) upd[14] = v[0];
         `MEOC_OP_CTS: if (v < 2) upd[15] = v[0];
         `MEOC_OP_DSR: if (v < 2) upd[16] = v[0];
         `MEOC_OP_TRELLIS: if (v < 2) upd[17] = v[0];
         default: ;
      endcase
   endfunction
   task automatic cmd(input logic [3:0] op, v);
      opt = upd(opt, op, v);
      wb(1, `MEOC_ADDR_CMD, {20'h0, op, 4'h0, v}, 4'hf);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      rq.push_back(e);
      wb(0, a, 32'h0, 4'hf);
   endtask
   task automatic settle();
      repeat (6) @(posedge clk);
   endtask
   // ****************
   // Watchers and stimulus
   // ****************
   always @(posedge clk) begin
      if (dial_request === 1'b1) ndial++;
      if (wb_ack_o === 1'b1 && !wb_we_i && rq.size() > 0)
         cmp("read", rq.pop_front(), wb_dat_o);
      if (view_pulse === 1'b1 && vq.size() > 0)
         cmp("view", vq.pop_front(), view_profile);
   end
   always @(posedge clk) begin
      ncyc++;
      if (ncyc > 20000) begin
         n_mismatch++;
         finish_test();
      end
   end
   initial begin
      void'($urandom(33));
      repeat (5) @(posedge clk);
      reset <= 0;
      opt = OPT_RST;
      rd(`MEOC_ADDR_OPT, OPT_RST);
      rd(6'h14, 32'h0);
      wb(1, `MEOC_ADDR_OPT, 32'h0, 4'hf);
      wb(1, `MEOC_ADDR_CMD, {20'h0, `MEOC_OP_GUARD, 8'h01}, 4'h1);
      rd(`MEOC_ADDR_OPT, OPT_RST);
      repeat (60) begin
         @(posedge clk);
         {off_hook_pin, carrier_pin, handshake_pin, want_rts} <= 4'($urandom);
         op = 4'($urandom % 11);
         if (op == `MEOC_OP_TEST) op = `MEOC_OP_DEFAULTS;
         v = 4'($urandom);
         cmd(op, v);
         rd(`MEOC_ADDR_OPT, opt);
         settle();
         m = opt[13:11];
         sy = m > 0 && m < 4;
         cmp("pins", {opt[5:4] == 1, opt[5:4] == 2, opt[9:7] == 3,
            opt[9:7] == 4, opt[10], sy, opt[14], opt[17],
            opt[6] & off_hook_pin, (m == 0 && !opt[16]) |
            (handshake_pin & (off_hook_pin | carrier_pin))},
            {guard_550, guard_1800, hw_flow_en, sw_flow_en, leased_line,
            sync_mode, pulse_ratio_uk, trellis_coding_disable,
            relay_close, dsr_out});
         cmp("cts", off_hook_pin & (opt[15] | !sy | rts_pin), cts_out);
      end
      off_hook_pin <= 0;
      cmd(`MEOC_OP_MODE, 2);
      ndial = 0;
      want_dtr <= 1;
      settle();
      cmp("dial", 1, ndial);
      {off_hook_pin, want_dtr} <= 2'b10;
      settle();
      cmp("hangup", 1, hangup_request);
      cmd(`MEOC_OP_MODE, 3);
      want_dtr <= 1;
      settle();
      cmp("data", 1, data_mode);
      cmd(`MEOC_OP_MODE, 0);
      cmd(`MEOC_OP_DSR, 1);
      {off_hook_pin, handshake_pin} <= 2'b11;
      for (int i = 0; i < 5; i++) begin
         band_high_pin <= 1'($urandom);
         cmd(`MEOC_OP_TEST, tc[i]);
         settle();
         cmp("test", {ts[i], 1'b0}, {test_state, dsr_out});
         if (tc[i] == 1 || tc[i] == 8)
            cmp("band", band_high_pin, test_band_high);
         cmd(`MEOC_OP_TEST, `MEOC_TEST_END);
         settle();
         cmp("end", 1, {test_state, dsr_out});
      end
      rdl_request_pin <= 1;
      for (int k = 4; k < 6; k++) begin
         cmd(`MEOC_OP_TEST, 4'(k));
         rd(`MEOC_ADDR_CTL, k);
         settle();
         cmp("rdl", {2{k == 4}}, {rdl_grant, rdl_accept});
      end
      vq.push_back(2'b10);
      cmd(`MEOC_OP_VIEW, 0);
      vq.push_back(2'b11);
      cmd(`MEOC_OP_VIEW, 1);
      settle();
      cmp("views", 0, vq.size());
      ce <= 0;
      off_hook_pin <= 0;
      settle();
      cmp("freeze", 1, cts_out);
      ce <= 1;
      settle();
      cmp("thaw", 0, cts_out);
      finish_test();
   end
endmodule
`default_nettype wire
